/* File: verilog/usbec_defines.vh */
// ----------------------------------------------------------------------------
// Register indices, field positions, reset values and codes of the engine.
// ----------------------------------------------------------------------------
`ifndef USBEC_DEFINES_VH
`define USBEC_DEFINES_VH

// Word indices on the register bus; the byte address is four times the index.
`define USBEC_IDX_EP0_TX 7'h10
`define USBEC_IDX_EP1_TX 7'h11
`define USBEC_IDX_BUS_SC 7'h13
// Indices 0x70 to 0x7f reach the two endpoint FIFOs, upper index bits below.
`define USBEC_IDX_FIFO_HI 3'h7

// Reset values.
`define USBEC_RST_EP_TX 8'h00
`define USBEC_RST_BUS_SC 4'h0
`define USBEC_RST_CNT 4'h0

// Fields of the endpoint transmit registers; bit 4 is USBEC_BIT_EP1_EN on endpoint one and USBEC_BIT_RX_ERR on endpoint zero.
`define USBEC_BIT_READY 7
`define USBEC_BIT_TOGGLE 6
`define USBEC_BIT_STALL 5
`define USBEC_BIT_EP1_EN 4
`define USBEC_BIT_RX_ERR 4
`define USBEC_CNT_HI 3

// Fields of the bus status and control register.
`define USBEC_BIT_ACT 0
`define USBEC_BIT_FORCE_K 1
`define USBEC_BIT_FORCE_J 2
`define USBEC_BIT_AUTO 3
`define USBEC_BIT_OUT_EN 4

// Byte counts.
`define USBEC_MAX_TX_LEN 4'h8
`define USBEC_FIFO_BYTES 4'h8
`define USBEC_CRC_BYTES 4'h2
`define USBEC_CNT_SAT 4'hf

// Token kinds delivered by the packet layer.
`define USBEC_PID_OUT 2'h0
`define USBEC_PID_IN 2'h1
`define USBEC_PID_SETUP 2'h2

// Reply kinds handed back to the packet layer.
`define USBEC_REPLY_ACK 2'h0
`define USBEC_REPLY_NAK 2'h1
`define USBEC_REPLY_STALL 2'h2
`define USBEC_REPLY_DATA 2'h3

`endif

/* File: verilog/usbec_mem.v */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Endpoint FIFO storage: one write port, one read port with registered data.
// ----------------------------------------------------------------------------
module usbec_mem #(
  parameter AW = 4,
  parameter DW = 8
) (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Array write; the storage itself has no reset.
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data are held in a register until the next read.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= {DW{1'b0}};
    end
    else if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // usbec_mem

/* File: verilog/usbec_line_ctl.v */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Bus activity detection and forced J/K line states.
// ----------------------------------------------------------------------------
module usbec_line_ctl (
  input wire clk,
  input wire rst_n,
  input wire dp_in,
  input wire dm_in,
  input wire act_clr,
  input wire force_resume_state,
  input wire force_idle_state,
  input wire tx_dp,
  input wire tx_dm,
  input wire tx_oe,
  output reg bus_activity_flag,
  output reg dp_out,
  output reg dm_out,
  output reg d_oe
);

  wire line_idle;

  // Idle on a low-speed bus is D+ low with D- high.
  assign line_idle = ~dp_in & dm_in;

  // Any non-idle state sets the flag; a detection beats a clear.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_activity_flag <= 1'b0;
    end
    else if (!line_idle)
    begin
      bus_activity_flag <= 1'b1;
    end
    else if (act_clr)
    begin
      bus_activity_flag <= 1'b0;
    end
  end

  // Forcing K wins over forcing J, which wins over the packet transmitter.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      d_oe <= 1'b0;
    end
    else if (force_resume_state)
    begin
      dp_out <= 1'b1;
      dm_out <= 1'b0;
      d_oe <= 1'b1;
    end
    else if (force_idle_state)
    begin
      dp_out <= 1'b0;
      dm_out <= 1'b1;
      d_oe <= 1'b1;
    end
    else
    begin
      dp_out <= tx_dp;
      dm_out <= tx_dm;
      d_oe <= tx_oe;
    end
  end

endmodule // usbec_line_ctl

/* File: verilog/usbec_engine.v */
`timescale 1ns/1ps
`include "usbec_defines.vh"
module usbec_engine (
  input wire clk,
  input wire rst_n,
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire tok_valid,
  input wire [1:0] tok_pid,
  input wire [3:0] tok_endp,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire rx_end,
  input wire rx_err,
  input wire rx_data1,
  input wire hs_ack,
  output reg reply_valid,
  output reg [1:0] reply_code,
  output reg reply_data1,
  output reg [3:0] reply_len,
  input wire tx_rd_req,
  input wire [2:0] tx_rd_idx,
  output wire [7:0] tx_rd_data,
  output reg tx_rd_valid,
  output reg ep0_irq,
  output reg ep1_irq,
  output reg ep0_rx_toggle,
  output reg [3:0] ep0_rx_count,
  input wire dp_in,
  input wire dm_in,
  input wire tx_dp,
  input wire tx_dm,
  input wire tx_oe,
  output wire dp_out,
  output wire dm_out,
  output wire d_oe
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SETUP_DATA = 4'b0010;
  localparam [3:0] ST_OUT_DATA = 4'b0100;
  localparam [3:0] ST_IN_WAIT = 4'b1000;

  reg [3:0] state_q;
  reg [7:0] ep0_q;
  reg [7:0] ep1_q;
  reg [3:0] scr_q;
  reg [3:0] rx_cnt_q;
  reg store_q;
  reg m_stall_q;
  reg m_auto_q;
  reg m_en_q;
  reg in_ep_q;
  reg ack_q;
  reg pend_q;
  wire req;
  wire fw_fifo;
  wire eng_wr;
  wire go;
  wire fw_wr_fifo;
  wire fw_rd_grant;
  wire wr_lo;
  wire act_clr;
  wire bus_activity_flag;
  wire [7:0] mem_rd_data;
  wire status_ok;
  wire tok_ep0;
  wire tok_ep1;

  // Clamp a requested IN length so a packet never reads past the FIFO.
  function [3:0] in_len;
    input [7:0] ctrl;
    begin
      if (ctrl[`USBEC_CNT_HI:0] > `USBEC_MAX_TX_LEN)
      begin
        in_len = `USBEC_MAX_TX_LEN;
      end
      else
      begin
        in_len = ctrl[`USBEC_CNT_HI:0];
      end
    end
  endfunction

  // Reply to an IN token: STALL first, then data when armed, else NAK.
  function [1:0] in_reply;
    input [7:0] ctrl;
    begin
      if (ctrl[`USBEC_BIT_STALL])
      begin
        in_reply = `USBEC_REPLY_STALL;
      end
      else if (ctrl[`USBEC_BIT_READY])
      begin
        in_reply = `USBEC_REPLY_DATA;
      end
      else
      begin
        in_reply = `USBEC_REPLY_NAK;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register bus slave and FIFO arbitration
  // --------------------------------------------------------------------------
  // The packet engine owns both memory ports first; firmware waits for a gap.
  assign req = avs_read | avs_write;
  assign fw_fifo = (avs_address[6:4] == `USBEC_IDX_FIFO_HI);
  assign eng_wr = rx_byte_valid & store_q & (rx_cnt_q < `USBEC_FIFO_BYTES) &
                  (state_q != ST_IDLE) & (state_q != ST_IN_WAIT);
  assign fw_wr_fifo = avs_write & fw_fifo & avs_byteenable[0];
  assign go = req & ack_q & ~(fw_wr_fifo & eng_wr);
  assign avs_waitrequest = req & ~go;
  assign fw_rd_grant = avs_read & fw_fifo & ~ack_q & ~pend_q & ~tx_rd_req;
  assign wr_lo = go & avs_write & avs_byteenable[0];
  assign act_clr = wr_lo & (avs_address == `USBEC_IDX_BUS_SC) &
                   ~avs_writedata[`USBEC_BIT_ACT];
  assign tx_rd_data = mem_rd_data;

  // Answer timing: registers after one wait cycle, FIFO reads after two.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      tx_rd_valid <= 1'b0;
    end
    else
    begin
      tx_rd_valid <= tx_rd_req;
      if (go)
      begin
        ack_q <= 1'b0;
      end
      else if (pend_q)
      begin
        pend_q <= 1'b0;
        ack_q <= 1'b1;
        avs_readdata <= {24'h000000, mem_rd_data};
      end
      else if (fw_rd_grant)
      begin
        pend_q <= 1'b1;
      end
      else if (req & ~ack_q & ~(avs_read & fw_fifo))
      begin
        ack_q <= 1'b1;
        case (avs_address)
          `USBEC_IDX_EP0_TX: avs_readdata <= {24'h000000, ep0_q};
          `USBEC_IDX_EP1_TX: avs_readdata <= {24'h000000, ep1_q};
          `USBEC_IDX_BUS_SC: avs_readdata <= {27'h0000000, scr_q, bus_activity_flag};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Endpoint state, register updates and replies
  // --------------------------------------------------------------------------
  assign tok_ep0 = tok_valid & (tok_endp == 4'h0);
  assign tok_ep1 = tok_valid & (tok_endp == 4'h1);
  assign status_ok = rx_data1 & (rx_cnt_q == `USBEC_CRC_BYTES);

  // Firmware writes land first; hardware updates in the same cycle override.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      ep0_q <= `USBEC_RST_EP_TX;
      ep1_q <= `USBEC_RST_EP_TX;
      scr_q <= `USBEC_RST_BUS_SC;
      rx_cnt_q <= `USBEC_RST_CNT;
      store_q <= 1'b0;
      m_stall_q <= 1'b0;
      m_auto_q <= 1'b0;
      m_en_q <= 1'b0;
      in_ep_q <= 1'b0;
      reply_valid <= 1'b0;
      reply_code <= `USBEC_REPLY_ACK;
      reply_data1 <= 1'b0;
      reply_len <= 4'h0;
      ep0_irq <= 1'b0;
      ep1_irq <= 1'b0;
      ep0_rx_toggle <= 1'b0;
      ep0_rx_count <= `USBEC_RST_CNT;
    end
    else
    begin
      reply_valid <= 1'b0;
      ep0_irq <= 1'b0;
      ep1_irq <= 1'b0;
      if (wr_lo & (avs_address == `USBEC_IDX_EP0_TX))
      begin
        ep0_q <= avs_writedata[7:0];
      end
      if (wr_lo & (avs_address == `USBEC_IDX_EP1_TX))
      begin
        ep1_q <= avs_writedata[7:0];
      end
      if (wr_lo & (avs_address == `USBEC_IDX_BUS_SC))
      begin
        scr_q <= avs_writedata[4:1];
      end
      if (eng_wr & (rx_cnt_q != `USBEC_CNT_SAT))
      begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end
      else if (rx_byte_valid & (rx_cnt_q != `USBEC_CNT_SAT) & (state_q != ST_IDLE))
      begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end
      if (tok_ep0 & (tok_pid == `USBEC_PID_SETUP))
      begin
        ep0_q[`USBEC_BIT_STALL] <= 1'b0;
        ep0_q[`USBEC_BIT_READY] <= 1'b0;
        scr_q[`USBEC_BIT_AUTO-1] <= 1'b0;
        scr_q[`USBEC_BIT_OUT_EN-1] <= 1'b0;
        store_q <= 1'b1;
        rx_cnt_q <= `USBEC_RST_CNT;
        state_q <= ST_SETUP_DATA;
      end
      else if (tok_ep0 & (tok_pid == `USBEC_PID_OUT))
      begin
        m_stall_q <= ep0_q[`USBEC_BIT_STALL];
        m_auto_q <= scr_q[`USBEC_BIT_AUTO-1];
        m_en_q <= scr_q[`USBEC_BIT_OUT_EN-1];
        // Auto status and stall both keep OUT data out of the FIFO.
        store_q <= scr_q[`USBEC_BIT_OUT_EN-1] & ~scr_q[`USBEC_BIT_AUTO-1] &
                   ~ep0_q[`USBEC_BIT_STALL];
        rx_cnt_q <= `USBEC_RST_CNT;
        state_q <= ST_OUT_DATA;
      end
      else if ((tok_ep0 | (tok_ep1 & ep1_q[`USBEC_BIT_EP1_EN])) &
               (tok_pid == `USBEC_PID_IN))
      begin
        reply_valid <= 1'b1;
        reply_code <= in_reply(tok_ep0 ? ep0_q : ep1_q);
        reply_data1 <= tok_ep0 ? ep0_q[`USBEC_BIT_TOGGLE] :
                       ep1_q[`USBEC_BIT_TOGGLE];
        reply_len <= in_len(tok_ep0 ? ep0_q : ep1_q);
        in_ep_q <= tok_ep1;
        store_q <= 1'b0;
        if (in_reply(tok_ep0 ? ep0_q : ep1_q) == `USBEC_REPLY_DATA)
        begin
          state_q <= ST_IN_WAIT;
        end
        else
        begin
          state_q <= ST_IDLE;
        end
      end
      else if (tok_ep1 & ep1_q[`USBEC_BIT_EP1_EN] & (tok_pid == `USBEC_PID_OUT))
      begin
        // Transmit-only endpoint: an OUT is answered only while stalled.
        reply_valid <= ep1_q[`USBEC_BIT_STALL];
        reply_code <= `USBEC_REPLY_STALL;
        store_q <= 1'b0;
        state_q <= ST_IDLE;
      end
      else if (tok_valid)
      begin
        // Traffic to a disabled or absent endpoint is dropped silently.
        store_q <= 1'b0;
        state_q <= ST_IDLE;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            state_q <= ST_IDLE;
          end
          ST_SETUP_DATA:
          begin
            if (rx_end)
            begin
              ep0_rx_toggle <= rx_data1;
              ep0_rx_count <= rx_cnt_q;
              ep0_irq <= 1'b1;
              reply_valid <= ~rx_err;
              reply_code <= `USBEC_REPLY_ACK;
              if (rx_err)
              begin
                ep0_q[`USBEC_BIT_RX_ERR] <= 1'b1;
              end
              store_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          ST_OUT_DATA:
          begin
            if (rx_end)
            begin
              if (rx_err)
              begin
                ep0_q[`USBEC_BIT_RX_ERR] <= 1'b1;
              end
              reply_valid <= ~rx_err;
              if (m_stall_q)
              begin
                reply_code <= `USBEC_REPLY_STALL;
              end
              else if (m_auto_q)
              begin
                ep0_rx_toggle <= rx_data1;
                if (!rx_err)
                begin
                  ep0_rx_count <= rx_cnt_q;
                  ep0_irq <= 1'b1;
                end
                reply_code <= status_ok ? `USBEC_REPLY_ACK :
                              `USBEC_REPLY_STALL;
              end
              else if (m_en_q)
              begin
                ep0_rx_toggle <= rx_data1;
                ep0_rx_count <= rx_cnt_q;
                ep0_irq <= 1'b1;
                reply_code <= `USBEC_REPLY_ACK;
                if (!rx_err)
                begin
                  scr_q[`USBEC_BIT_OUT_EN-1] <= 1'b0;
                end
              end
              else
              begin
                reply_code <= `USBEC_REPLY_NAK;
              end
              store_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          ST_IN_WAIT:
          begin
            if (hs_ack)
            begin
              if (in_ep_q)
              begin
                ep1_q[`USBEC_BIT_READY] <= 1'b0;
                ep1_irq <= 1'b1;
              end
              else
              begin
                ep0_q[`USBEC_BIT_READY] <= 1'b0;
                ep0_irq <= 1'b1;
              end
              state_q <= ST_IDLE;
            end
          end
          default:
          begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------------------
  // Lower half holds endpoint zero, upper half endpoint one.
  usbec_mem #(
    .AW(4),
    .DW(8)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(eng_wr | (go & fw_wr_fifo)),
    .wr_addr(eng_wr ? {1'b0, rx_cnt_q[2:0]} : avs_address[3:0]),
    .wr_data(eng_wr ? rx_byte : avs_writedata[7:0]),
    .rd_en(tx_rd_req | fw_rd_grant),
    .rd_addr(tx_rd_req ? {in_ep_q, tx_rd_idx} : avs_address[3:0]),
    .rd_data(mem_rd_data)
  );

  // Line monitor and forced line states.
  usbec_line_ctl u_line (
    .clk(clk),
    .rst_n(rst_n),
    .dp_in(dp_in),
    .dm_in(dm_in),
    .act_clr(act_clr),
    .force_resume_state(scr_q[`USBEC_BIT_FORCE_K-1]),
    .force_idle_state(scr_q[`USBEC_BIT_FORCE_J-1]),
    .tx_dp(tx_dp),
    .tx_dm(tx_dm),
    .tx_oe(tx_oe),
    .bus_activity_flag(bus_activity_flag),
    .dp_out(dp_out),
    .dm_out(dm_out),
    .d_oe(d_oe)
  );

endmodule // usbec_engine

/* File: verif/usbec_engine_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checks of the endpoint engine.
// ----------------------------------------------------------------------------
module usbec_engine_assertions (
  input wire clk,
  input wire rst_n,
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire tok_valid,
  input wire [1:0] tok_pid,
  input wire [3:0] tok_endp,
  input wire rx_end,
  input wire rx_err,
  input wire reply_valid,
  input wire [1:0] reply_code,
  input wire tx_rd_req,
  input wire tx_rd_valid,
  input wire ep0_irq,
  input wire dp_out,
  input wire dm_out,
  input wire d_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg setup_q;
  // Decoded bus events: FIFO window and completed control register writes.
  wire fifo = avs_address[6:4] == 3'h7;
  wire sc_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 7'h13;
  // Remembers whether the last token was a SETUP to endpoint zero.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      setup_q <= 1'b0;
    else if (tok_valid)
      setup_q <= tok_pid == 2'h2 && tok_endp == 4'h0;
  end
  chk_wait_reg: assert property (
    (avs_read || avs_write) && !fifo |-> ##[0:1] !avs_waitrequest)
    else $error("register access not answered in time");
  chk_rd_upper: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_force_k: assert property (
    sc_wr && avs_writedata[1] |-> ##2 dp_out && !dm_out && d_oe)
    else $error("resume state not driven");
  chk_force_j: assert property (
    sc_wr && avs_writedata[2:1] == 2'h2 |-> ##2 !dp_out && dm_out && d_oe)
    else $error("idle state not driven");
  chk_err_quiet: assert property (rx_end && rx_err |=> !reply_valid)
    else $error("errored data got a reply");
  chk_setup_ack: assert property (
    rx_end && !rx_err && setup_q |=> reply_valid && reply_code == 2'h0)
    else $error("setup data not acknowledged");
  chk_setup_irq: assert property (rx_end && setup_q |=> ep0_irq)
    else $error("setup data raised no interrupt");
  chk_rd_valid: assert property (tx_rd_req |=> tx_rd_valid)
    else $error("transmit byte not delivered");
  chk_reply_pulse: assert property (reply_valid |=> !reply_valid)
    else $error("reply strobe longer than one cycle");
  cov_setup: cover property (rx_end && setup_q);
  cov_force: cover property (sc_wr && avs_writedata[1]);
  cov_fifo_rd: cover property (avs_read && fifo && !avs_waitrequest);
endmodule // usbec_engine_assertions

/* File: verif/usbec_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host and packet layer stand-in on the bus side of the engine.
// ----------------------------------------------------------------------------
module usbec_host (
  input wire clk,
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic [3:0] tok_endp,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_end,
  output logic rx_err,
  output logic rx_data1,
  output logic hs_ack,
  output logic tx_rd_req,
  output logic [2:0] tx_rd_idx,
  output logic dp_in,
  output logic dm_in
);
  // Quiet bus at time zero; the minus line idles high through its pull-up.
  initial
  begin
    {tok_valid, tok_pid, tok_endp, rx_byte_valid, rx_byte} = 16'h0;
    {rx_end, rx_err, rx_data1, hs_ack, tx_rd_req, tx_rd_idx} = 8'h0;
    dp_in = 1'b0;
    dm_in = 1'b1;
  end
  // One token strobe.
  task token(input logic [1:0] p, input logic [3:0] e);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_endp <= e;
    @(posedge clk);
    tok_valid <= 1'b0;
  endtask
  // Data packet of n bytes including the two CRC bytes, at most eight data bytes.
  task data(input int n, input logic d1, input logic err);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'ha0 + i[7:0];
    end
    @(posedge clk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_end <= 1'b1;
    rx_err <= err;
    rx_data1 <= d1;
    @(posedge clk);
    rx_end <= 1'b0;
    rx_err <= 1'b0;
  endtask
  // Host handshake on our data packet.
  task ack;
    @(posedge clk);
    hs_ack <= 1'b1;
    @(posedge clk);
    hs_ack <= 1'b0;
  endtask
  // Fetch one transmit byte; it stands on the edge at which the task returns.
  task fetch(input logic [2:0] i);
    @(posedge clk);
    tx_rd_req <= 1'b1;
    tx_rd_idx <= i;
    @(posedge clk);
    tx_rd_req <= 1'b0;
    @(posedge clk);
  endtask
  // Short K state on the lines, then back to idle.
  task wake;
    @(posedge clk);
    dp_in <= 1'b1;
    dm_in <= 1'b0;
    repeat (4) @(posedge clk);
    dp_in <= 1'b0;
    dm_in <= 1'b1;
  endtask
endmodule // usbec_host

/* File: verif/usbec_engine_test.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Self-checking bench of the endpoint engine.
// ----------------------------------------------------------------------------
module usbec_engine_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] avs_address = 7'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, tok_valid, rx_byte_valid, rx_end, rx_err, rx_data1, hs_ack;
  wire tx_rd_req, dp_in, dm_in, reply_valid, reply_data1, tx_rd_valid, ep0_irq, ep1_irq;
  wire ep0_rx_toggle, dp_out, dm_out, d_oe;
  wire [1:0] tok_pid, reply_code;
  wire [3:0] tok_endp, reply_len, ep0_rx_count;
  wire [7:0] rx_byte, tx_rd_data;
  wire [2:0] tx_rd_idx;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rdat;
  logic [2:0] rp;
  logic [1:0] ir;
  logic [4:0] lr;
  usbec_engine u_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tok_valid, .tok_pid, .tok_endp,
    .rx_byte_valid, .rx_byte, .rx_end, .rx_err, .rx_data1, .hs_ack, .reply_valid, .reply_code,
    .reply_data1, .reply_len, .tx_rd_req, .tx_rd_idx, .tx_rd_data, .tx_rd_valid, .ep0_irq,
    .ep1_irq, .ep0_rx_toggle, .ep0_rx_count, .dp_in, .dm_in, .tx_dp(1'b0), .tx_dm(1'b0),
    .tx_oe(1'b0), .dp_out, .dm_out, .d_oe);
  usbec_host u_host (.clk, .tok_valid, .tok_pid, .tok_endp, .rx_byte_valid, .rx_byte, .rx_end,
    .rx_err, .rx_data1, .hs_ack, .tx_rd_req, .tx_rd_idx, .dp_in, .dm_in);
  // Clock and hang guard.
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count = err_count + 1;
      results();
    end
  end
  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low.
  task bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rdat = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rchk(input logic [6:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rdat, exp);
  endtask
  // Collects reply (4 means none) and interrupt pulses over three cycles.
  task cap;
    rp = 3'h4;
    ir = 2'h0;
    repeat (3)
    begin
      @(posedge clk);
      if (reply_valid === 1'b1)
      begin
        rp = {1'b0, reply_code};
        lr = {reply_data1, reply_len};
      end
      ir = ir | {ep0_irq, ep1_irq};
    end
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------------
  task t_regs;
    rchk(7'h10, 8'h00);
    rchk(7'h11, 8'h00);
    rchk(7'h13, 8'h00);
    bus(1'b1, 7'h15, 8'hff);
    rchk(7'h15, 8'h00);
    avs_byteenable <= 4'he;
    bus(1'b1, 7'h11, 8'h58);
    avs_byteenable <= 4'hf;
    rchk(7'h11, 8'h00);
    bus(1'b1, 7'h11, 8'h58);
    rchk(7'h11, 8'h58);
    $display("register test done");
  endtask
  task t_ep1;
    bus(1'b1, 7'h78, 8'h5a);
    bus(1'b1, 7'h7a, 8'hc3);
    bus(1'b1, 7'h11, 8'hd3);
    u_host.token(2'h1, 4'h1);
    cap;
    check({ir, rp}, 5'h03);
    check(lr, 5'h13);
    u_host.fetch(3'h2);
    check({tx_rd_valid, tx_rd_data}, 9'h1c3);
    u_host.ack;
    cap;
    check({ir, rp}, 5'h0c);
    rchk(7'h11, 8'h53);
    u_host.token(2'h1, 4'h1);
    cap;
    check({ir, rp}, 5'h01);
    bus(1'b1, 7'h11, 8'h30);
    u_host.token(2'h1, 4'h1);
    cap;
    check({ir, rp}, 5'h02);
    u_host.token(2'h0, 4'h1);
    cap;
    check({ir, rp}, 5'h02);
    bus(1'b1, 7'h11, 8'h98);
    u_host.token(2'h1, 4'h1);
    cap;
    check(lr, 5'h08);
    bus(1'b1, 7'h11, 8'h00);
    u_host.token(2'h1, 4'h1);
    cap;
    check({ir, rp}, 5'h04);
    $display("endpoint one test done");
  endtask
  task t_ep0;
    bus(1'b1, 7'h13, 8'h10);
    u_host.token(2'h0, 4'h0);
    u_host.data(4, 1'b0, 1'b0);
    cap;
    check({ir, rp}, 5'h10);
    check(ep0_rx_count, 4'h4);
    rchk(7'h13, 8'h00);
    u_host.token(2'h0, 4'h0);
    u_host.data(4, 1'b1, 1'b0);
    cap;
    check({ir, rp}, 5'h01);
    bus(1'b1, 7'h13, 8'h08);
    u_host.token(2'h0, 4'h0);
    u_host.data(2, 1'b1, 1'b0);
    cap;
    check({ir, rp}, 5'h10);
    check(ep0_rx_toggle, 1'b1);
    u_host.token(2'h0, 4'h0);
    u_host.data(2, 1'b0, 1'b0);
    cap;
    check({ir, rp}, 5'h12);
    bus(1'b1, 7'h10, 8'ha0);
    bus(1'b1, 7'h13, 8'h18);
    u_host.token(2'h2, 4'h0);
    u_host.data(10, 1'b0, 1'b0);
    cap;
    check({ir, rp}, 5'h10);
    check(ep0_rx_toggle, 1'b0);
    rchk(7'h10, 8'h00);
    rchk(7'h13, 8'h00);
    rchk(7'h70, 8'ha0);
    u_host.token(2'h2, 4'h0);
    u_host.data(4, 1'b0, 1'b1);
    cap;
    check({ir, rp}, 5'h14);
    rchk(7'h10, 8'h10);
    bus(1'b1, 7'h70, 8'h11);
    bus(1'b1, 7'h10, 8'hc2);
    u_host.token(2'h1, 4'h0);
    cap;
    check({ir, rp, lr}, 10'h072);
    $display("endpoint zero test done");
  endtask
  task t_line;
    bus(1'b1, 7'h13, 8'h04);
    repeat (2) @(posedge clk);
    check({d_oe, dp_out, dm_out}, 3'h5);
    bus(1'b1, 7'h13, 8'h02);
    repeat (2) @(posedge clk);
    check({d_oe, dp_out, dm_out}, 3'h6);
    bus(1'b1, 7'h13, 8'h00);
    u_host.wake;
    check({d_oe, dp_out, dm_out}, 3'h0);
    rchk(7'h13, 8'h01);
    bus(1'b1, 7'h13, 8'h01);
    rchk(7'h13, 8'h01);
    bus(1'b1, 7'h13, 8'h00);
    rchk(7'h13, 8'h00);
    $display("line test done");
  endtask
  // Prints the counts and the verdict, then stops.
  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_ep1;
    t_ep0;
    t_line;
    results;
  end
endmodule // usbec_engine_test
bind usbec_engine usbec_engine_assertions u_chk (.clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .tok_valid,
  .tok_pid, .tok_endp, .rx_end, .rx_err, .reply_valid, .reply_code, .tx_rd_req, .tx_rd_valid,
  .ep0_irq, .dp_out, .dm_out, .d_oe);
